// File: serial_baud_and_lin_break_config.sv
// data buffer, baud generator and break control with an APB register port
// =====================================================
`timescale 1ns/1ns
`include "serial_baud_defs.svh"
module serial_baud_and_lin_break_config
   import serial_baud_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        oscillatorClock,
   input  wire logic        charLength9,
   input  wire logic        rxLoad,
   input  wire logic [7:0]  rxByte,
   output      logic [7:0]  txByte,
   output      logic        txLoad,
   input  wire logic        serialIn,
   output      logic        breakLineLow,
   output      logic        serialModuleEnable,
   output      logic        rtTick,
   output      logic        bitTick
);

   typedef struct packed
   {
      logic         pready;
      logic         pslverr;
      logic [7:0]   prdata;
      logic         masterBreakTransmitEnable;
      logic         slaveBreakDetectEnable;
      logic [1:0]   coarsePrescaleSelect;
      logic [2:0]   rateDivisorSelect;
      logic [2:0]   integerPrescaleCode;
      logic [4:0]   clockInsertionSelect;
      logic         serialModuleEnable;
      logic         baudSourceSelect;
      logic         oscPrev;
      logic         sourceTick;
      logic         txLoad;
      logic         breakSeen;
      tx_state_type txState;
      logic [3:0]   txCount;
      logic         breakLineLow;
      rx_state_type rxState;
      logic [7:0]   rxCount;
   } ctrl_state_type;

   typedef struct packed
   {
      logic [7:0] rxBuffer;
      logic [7:0] txBuffer;
   } data_buffer_type;

   ctrl_state_type  state;
   ctrl_state_type  next_state;
   data_buffer_type bufs;
   data_buffer_type next_bufs;

   logic       setupCycle;
   logic       writeDone;
   logic       startBreak;
   logic       clearBreak;
   logic [3:0] coarsePrescaleDivisor;
   logic [3:0] txBreakBits;
   logic [3:0] rxBreakBits;
   logic [7:0] rxThreshold;
   logic       preTick;
   logic       coarseTick;

   // =====================================================
   // baud chain
   always_comb
   begin
      unique case (state.coarsePrescaleSelect)
         2'b00: coarsePrescaleDivisor = `COARSE_DIV_0;
         2'b01: coarsePrescaleDivisor = `COARSE_DIV_1;
         2'b10: coarsePrescaleDivisor = `COARSE_DIV_2;
         2'b11: coarsePrescaleDivisor = `COARSE_DIV_3;
      endcase
      if (state.masterBreakTransmitEnable)
         txBreakBits = charLength9 ? `TX_BREAK_LIN_9 : `TX_BREAK_LIN_8;
      else
         txBreakBits = charLength9 ? `TX_BREAK_NORMAL_9 : `TX_BREAK_NORMAL_8;
      if (state.slaveBreakDetectEnable)
         rxBreakBits = charLength9 ? `RX_BREAK_LIN_9 : `RX_BREAK_LIN_8;
      else
         rxBreakBits = charLength9 ? `RX_BREAK_NORMAL_9 : `RX_BREAK_NORMAL_8;
      // threshold in receiver ticks, sixteen per bit
      rxThreshold = {rxBreakBits, 4'h0};
   end

   fine_prescaler u_prescale
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .clear   (!state.serialModuleEnable),
      .tickIn  (state.sourceTick),
      .code    (state.integerPrescaleCode),
      .fine    (state.clockInsertionSelect),
      .tickOut (preTick)
   );

   // four times the coarse divisor, sixteen ticks per bit make 64
   tick_divider #(.WIDTH(6)) u_coarse
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .clear   (!state.serialModuleEnable),
      .tickIn  (preTick),
      .divisor ({coarsePrescaleDivisor, 2'b00}),
      .tickOut (coarseTick)
   );

   tick_divider #(.WIDTH(8)) u_rate
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .clear   (!state.serialModuleEnable),
      .tickIn  (coarseTick),
      .divisor (8'h01 << state.rateDivisorSelect),
      .tickOut (rtTick)
   );

   // bit clock for the break transmitter; the break detector counts rtTick instead
   tick_divider #(.WIDTH(5)) u_bit
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .clear   (!state.serialModuleEnable),
      .tickIn  (rtTick),
      .divisor (`RT_PER_BIT),
      .tickOut (bitTick)
   );

   // =====================================================
   // registers and break control
   always_comb
   begin
      next_state = state;
      next_bufs = bufs;
      setupCycle = psel && !penable;
      writeDone = psel && penable && pready && pwrite;
      startBreak = 1'b0;
      clearBreak = 1'b0;
      next_state.pready = setupCycle;
      next_state.txLoad = 1'b0;
      next_state.oscPrev = oscillatorClock;
      next_state.sourceTick = state.baudSourceSelect ? (oscillatorClock && !state.oscPrev) : 1'b1;
      if (rxLoad)
         next_bufs.rxBuffer = rxByte;
      if (setupCycle)
      begin
         next_state.pslverr = 1'b0;
         next_state.prdata = 8'h00;
         case (paddr)
            `DATA_BUFFER_OFFSET: next_state.prdata = bufs.rxBuffer;
            `BAUD_CONTROL_OFFSET: next_state.prdata = {state.masterBreakTransmitEnable,
               state.slaveBreakDetectEnable, state.coarsePrescaleSelect, 1'b0, state.rateDivisorSelect};
            `PRESCALER_OFFSET: next_state.prdata = {state.integerPrescaleCode, state.clockInsertionSelect};
            `CONFIG_OFFSET: next_state.prdata = {5'h00, state.txState == TX_BREAK,
               state.baudSourceSelect, state.serialModuleEnable};
            `STATUS_OFFSET: next_state.prdata = {6'h00, state.txState == TX_BREAK, state.breakSeen};
            default: next_state.pslverr = 1'b1;
         endcase
      end
      if (writeDone)
      begin
         case (paddr)
            `DATA_BUFFER_OFFSET:
            begin
               next_bufs.txBuffer = pwdata[7:0];
               next_state.txLoad = 1'b1;
            end
            `BAUD_CONTROL_OFFSET:
            begin
               next_state.masterBreakTransmitEnable = pwdata[`MASTER_BREAK_BIT];
               next_state.slaveBreakDetectEnable = pwdata[`SLAVE_BREAK_BIT];
               next_state.coarsePrescaleSelect = pwdata[`COARSE_MSB:`COARSE_LSB];
               next_state.rateDivisorSelect = pwdata[`RATE_MSB:`RATE_LSB];
            end
            `PRESCALER_OFFSET:
            begin
               next_state.integerPrescaleCode = pwdata[`PRESCALE_MSB:`PRESCALE_LSB];
               next_state.clockInsertionSelect = pwdata[`FINE_MSB:`FINE_LSB];
            end
            `CONFIG_OFFSET:
            begin
               next_state.serialModuleEnable = pwdata[`ENABLE_BIT];
               next_state.baudSourceSelect = pwdata[`SOURCE_BIT];
               startBreak = pwdata[`SEND_BREAK_BIT] && pwdata[`ENABLE_BIT];
            end
            `STATUS_OFFSET: clearBreak = pwdata[`BREAK_SEEN_BIT];
            default: ;
         endcase
      end
      // break transmitter, counts whole bit times
      unique case (state.txState)
         TX_IDLE:
         begin
            if (startBreak)
            begin
               next_state.txState = TX_BREAK;
               next_state.txCount = 4'h0;
               next_state.breakLineLow = 1'b1;
            end
         end
         TX_BREAK:
         begin
            if (!state.serialModuleEnable)
            begin
               next_state.txState = TX_IDLE;
               next_state.breakLineLow = 1'b0;
            end
            else if (bitTick)
            begin
               if (state.txCount == txBreakBits - 4'h1)
               begin
                  next_state.txState = TX_IDLE;
                  next_state.breakLineLow = 1'b0;
               end
               else
               begin
                  next_state.txCount = state.txCount + 4'h1;
               end
            end
         end
      endcase
      // break detector, re-armed only after the line returns high
      if (clearBreak)
         next_state.breakSeen = 1'b0;
      unique case (state.rxState)
         RX_WAIT_HIGH:
         begin
            next_state.rxCount = 8'h00;
            if (serialIn && state.serialModuleEnable)
               next_state.rxState = RX_ARMED;
         end
         RX_ARMED:
         begin
            if (serialIn || !state.serialModuleEnable)
            begin
               next_state.rxCount = 8'h00;
            end
            else if (rtTick)
            begin
               if (state.rxCount == rxThreshold - 8'h01)
               begin
                  next_state.breakSeen = 1'b1; // set wins over clear
                  next_state.rxState = RX_WAIT_HIGH;
               end
               next_state.rxCount = state.rxCount + 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= '0;
         state.txState <= TX_IDLE;
         state.rxState <= RX_WAIT_HIGH;
      end
      else
      begin
         state <= next_state;
      end
   end

   // no reset on the data buffer
   always_ff @(posedge sys_clk)
   begin
      bufs <= next_bufs;
   end

   assign prdata = {24'h000000, state.prdata};
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign txByte = bufs.txBuffer;
   assign txLoad = state.txLoad;
   assign breakLineLow = state.breakLineLow;
   assign serialModuleEnable = state.serialModuleEnable;

   // =====================================================
   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_data_read_setup;
      psel && !penable && !pwrite && paddr == `DATA_BUFFER_OFFSET;
   endsequence

   sequence s_data_write_done;
      psel && penable && pready && pwrite && paddr == `DATA_BUFFER_OFFSET;
   endsequence

   a_rx_read_data: assert property (s_data_read_setup |=> pready && prdata[7:0] == $past(bufs.rxBuffer))
      else $error("data read did not return the received byte");

   a_tx_write_load: assert property (s_data_write_done |=> txLoad && txByte == $past(pwdata[7:0]))
      else $error("data write did not load the transmit byte");

   a_break_tx_length: assert property ($fell(breakLineLow) && $past(state.serialModuleEnable)
      |-> $past(state.txCount) == $past(txBreakBits) - 4'h1 && $past(bitTick))
      else $error("transmitted break has the wrong length");

   a_break_rx_filter: assert property ($rose(state.breakSeen)
      |-> !$past(serialIn) && $past(state.rxCount) == $past(rxThreshold) - 8'h01)
      else $error("break flagged before the threshold");

   a_source_select: assert property (!state.baudSourceSelect |=> state.sourceTick)
      else $error("bus clock source did not tick every cycle");

   a_reset_clear: assert property (@(posedge sys_clk) disable iff (1'b0)
      $rose(rstn) |-> state.coarsePrescaleSelect == 2'b00 && state.rateDivisorSelect == 3'h0
      && state.integerPrescaleCode == 3'h0 && state.clockInsertionSelect == 5'h00
      && !state.masterBreakTransmitEnable && !state.slaveBreakDetectEnable)
      else $error("baud fields not cleared by reset");

endmodule : serial_baud_and_lin_break_config

// File: serial_baud_defs.svh
// register map, field positions, reset values and counts of the baud block
`ifndef SERIAL_BAUD_DEFS_SVH
`define SERIAL_BAUD_DEFS_SVH

// byte addresses
`define DATA_BUFFER_OFFSET     12'h018
`define BAUD_CONTROL_OFFSET    12'h01C
`define PRESCALER_OFFSET       12'h020
`define CONFIG_OFFSET          12'h024
`define STATUS_OFFSET          12'h028

// baud_rate_and_lin_control fields
`define MASTER_BREAK_BIT       7
`define SLAVE_BREAK_BIT        6
`define COARSE_MSB             5
`define COARSE_LSB             4
`define RATE_MSB               2
`define RATE_LSB               0

// baud_prescaler_fine_adjust fields
`define PRESCALE_MSB           7
`define PRESCALE_LSB           5
`define FINE_MSB               4
`define FINE_LSB               0

// configuration and status fields
`define ENABLE_BIT             0
`define SOURCE_BIT             1
`define SEND_BREAK_BIT         2
`define BREAK_SEEN_BIT         0
`define BREAK_SENDING_BIT      1

// reset values
`define BAUD_CONTROL_RESET     8'h00
`define PRESCALER_RESET        8'h00
`define CONFIG_RESET           8'h00

// coarse prescale divisors
`define COARSE_DIV_0           4'h1
`define COARSE_DIV_1           4'h3
`define COARSE_DIV_2           4'h4
`define COARSE_DIV_3           4'hD

// receiver ticks per bit and fine-adjust frame
`define RT_PER_BIT             5'h10
`define FINE_FRAME             6'h20

// break lengths in bit times
`define TX_BREAK_NORMAL_8      4'hA
`define TX_BREAK_NORMAL_9      4'hB
`define TX_BREAK_LIN_8         4'hD
`define TX_BREAK_LIN_9         4'hE
`define RX_BREAK_NORMAL_8      4'hA
`define RX_BREAK_NORMAL_9      4'hB
`define RX_BREAK_LIN_8         4'hB
`define RX_BREAK_LIN_9         4'hC

`endif

// File: serial_baud_pkg.sv
// state types of the baud and break block
package serial_baud_pkg;

   typedef enum logic {TX_IDLE, TX_BREAK} tx_state_type;
   typedef enum logic {RX_WAIT_HIGH, RX_ARMED} rx_state_type;

endpackage : serial_baud_pkg

// File: tick_divider.sv
// divides a tick stream by a run-time divisor
`timescale 1ns/1ns
module tick_divider
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic             clear,
   input  wire logic             tickIn,
   input  wire logic [WIDTH-1:0] divisor,
   output      logic             tickOut
);

   typedef struct packed
   {
      logic [WIDTH-1:0] count;
      logic             tickOut;
   } div_state_type;

   div_state_type state;
   div_state_type next_state;

   always_comb
   begin
      next_state = state;
      next_state.tickOut = 1'b0;
      if (clear)
      begin
         next_state.count = '0;
      end
      else if (tickIn)
      begin
         if (state.count >= divisor - WIDTH'(1))
         begin
            next_state.count = '0;
            next_state.tickOut = 1'b1;
         end
         else
         begin
            next_state.count = state.count + WIDTH'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         state <= '0;
      else
         state <= next_state;
   end

   assign tickOut = state.tickOut;

   // =====================================================
   // checks
   a_tick_source: assert property (@(posedge sys_clk) disable iff (!rstn)
      tickOut |-> $past(tickIn) && !$past(clear))
      else $error("divider ticked without an input tick");

endmodule : tick_divider

// File: fine_prescaler.sv
// integer prescaler with evenly spread clock insertion
`timescale 1ns/1ns
module fine_prescaler
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       clear,
   input  wire logic       tickIn,
   input  wire logic [2:0] code,
   input  wire logic [4:0] fine,
   output      logic       tickOut
);

   typedef struct packed
   {
      logic [3:0] count;
      logic [4:0] acc;
      logic       extra;
      logic       tickOut;
   } pre_state_type;

   pre_state_type state;
   pre_state_type next_state;
   logic [3:0]    lastCount;
   logic [5:0]    accSum;

   always_comb
   begin
      next_state = state;
      next_state.tickOut = 1'b0;
      // divide by code+1, plus one inserted clock when extra is set
      lastCount = {1'b0, code} + {3'h0, state.extra};
      accSum = {1'b0, state.acc} + {1'b0, fine};
      if (clear)
      begin
         next_state = '0;
      end
      else if (code == 3'h0)
      begin
         next_state.tickOut = tickIn;
      end
      else if (tickIn)
      begin
         if (state.count >= lastCount)
         begin
            next_state.count = 4'h0;
            next_state.tickOut = 1'b1;
            // accumulator carry spreads fine/32 insertions over the frame
            next_state.acc = accSum[4:0];
            next_state.extra = accSum[5];
         end
         else
         begin
            next_state.count = state.count + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         state <= '0;
      else
         state <= next_state;
   end

   assign tickOut = state.tickOut;

   // =====================================================
   // checks
   a_bypass_path: assert property (@(posedge sys_clk) disable iff (!rstn)
      (code == 3'h0 && !clear) |=> (tickOut == $past(tickIn)))
      else $error("bypass did not pass the source tick");

   a_fine_insert: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!clear && code != 3'h0 && tickIn && state.count >= lastCount && fine == 5'h00) |=> !state.extra)
      else $error("clock inserted with zero fine adjust");

endmodule : fine_prescaler

// File: remote_lin_node.sv
// remote serial node model: receive line, byte delivery and break timing
`timescale 1ns/1ns
module remote_lin_node
(
   input  wire logic       sys_clk,
   input  wire logic       rtTick,
   input  wire logic       bitTick,
   input  wire logic       breakLineLow,
   output      logic       serialIn,
   output      logic       rxLoad,
   output      logic [7:0] rxByte,
   output      int         breakBits
);
   logic lineWasLow;

   initial
   begin
      serialIn = 1'b1;
      rxLoad = 1'b0;
      rxByte = 8'h5A;
      breakBits = 0;
      lineWasLow = 1'b0;
   end

   // ====================
   // bit times of each break sent towards us
   always @(posedge sys_clk)
   begin
      if (breakLineLow === 1'b1 && lineWasLow !== 1'b1)
         breakBits <= (bitTick === 1'b1) ? 1 : 0;
      else if (breakLineLow === 1'b1 && bitTick === 1'b1)
         breakBits <= breakBits + 1;
      lineWasLow <= breakLineLow;
   end

   // ====================
   // one received byte; stale data scrambled afterwards
   task automatic deliver(input logic [7:0] b);
      @(posedge sys_clk);
      rxByte <= b;
      rxLoad <= 1'b1;
      @(posedge sys_clk);
      rxLoad <= 1'b0;
      rxByte <= ~b;
   endtask : deliver

   // dominant level for a count of receiver ticks
   task automatic hold_low(input int ticks, output logic ok);
      int seen;
      int cyc;
      seen = 0;
      cyc = 0;
      @(posedge sys_clk);
      serialIn <= 1'b0;
      while (seen < ticks && cyc < 100 * ticks)
      begin
         @(negedge sys_clk);
         cyc++;
         if (rtTick === 1'b1) seen++;
      end
      @(posedge sys_clk);
      serialIn <= 1'b1;
      ok = (seen == ticks);
   endtask : hold_low
endmodule : remote_lin_node

// File: serial_baud_and_lin_break_config_tb_top.sv
// self-checking bench of the data buffer, baud generator and break block
`timescale 1ns/1ns
`include "serial_baud_defs.svh"
module serial_baud_and_lin_break_config_tb_top;
   import serial_baud_pkg::*;
   logic        sys_clk;
   logic        rstn;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  oscDiv;
   logic        charLength9;
   logic        rxLoad;
   logic [7:0]  rxByte;
   logic [7:0]  txByte;
   logic        txLoad;
   logic        serialIn;
   logic        breakLineLow;
   logic        rtTick;
   logic        bitTick;
   logic        modEn;
   int          breakBits;
   int          fails;
   int          n_tests;
   logic [31:0] rd;
   logic        err;
   logic        ok;
   logic [7:0]  rxVal;
   logic [7:0]  txVal;
   logic [7:0]  cfg;
   logic [7:0]  pre;
   int          per;
   int          lenN;
   // {coarse, rate, integer code} per sweep step
   localparam logic [7:0] SWEEP [11] = '{8'h38, 8'hC1, 8'h92, 8'h4B, 8'h1C, 8'h05, 8'h46, 8'h07, 8'h20, 8'h28, 8'h30};

   serial_baud_and_lin_break_config dut_u (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .oscillatorClock(oscDiv[1]), .charLength9(charLength9), .rxLoad(rxLoad), .rxByte(rxByte), .txByte(txByte),
      .txLoad(txLoad), .serialIn(serialIn), .breakLineLow(breakLineLow), .serialModuleEnable(modEn), .rtTick(rtTick),
      .bitTick(bitTick));

   remote_lin_node peer (.sys_clk(sys_clk), .rtTick(rtTick), .bitTick(bitTick), .breakLineLow(breakLineLow),
      .serialIn(serialIn), .rxLoad(rxLoad), .rxByte(rxByte), .breakBits(breakBits));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // oscillator source rising every fourth cycle
   always @(posedge sys_clk) oscDiv <= oscDiv + 2'h1;

   // ====================
   // checking and bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task automatic give_up(input string what);
      fails++;
      $display("BAD t=%0t %s timed out", $time, what);
      wrap_up();
   endtask : give_up

   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) give_up("apb");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 8'h00);
      check(rd, exp, what);
   endtask : rdchk

   task automatic wait_bit(output int cyc);
      cyc = 0;
      do
      begin
         @(negedge sys_clk);
         cyc++;
      end
      while (bitTick !== 1'b1 && cyc < 40000);
      if (bitTick !== 1'b1) give_up("bit tick");
   endtask : wait_bit

   function automatic int exp_bit(input logic [7:0] e, input logic [4:0] f);
      int coarse_prescale_divisor;
      int bd;
      coarse_prescale_divisor = (e[7:6] == 2'h0) ? 1 : (e[7:6] == 2'h1) ? 3 : (e[7:6] == 2'h2) ? 4 : 13;
      bd = 1 << e[5:3];
      if (e[2:0] == 3'h0) return 64 * coarse_prescale_divisor * bd;
      return coarse_prescale_divisor * bd * (64 * (e[2:0] + 1) + 2 * f);
   endfunction : exp_bit

   // ====================
   // main sequence
   initial
   begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      charLength9 = 1'b0;
      oscDiv = 2'h0;
      fails = 0;
      n_tests = 0;
      per = $urandom(32'h45759d44);
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      rdchk(`BAUD_CONTROL_OFFSET, 32'h0, "baud reset");
      rdchk(`PRESCALER_OFFSET, 32'h0, "prescaler reset");
      rdchk(`CONFIG_OFFSET, 32'h0, "config reset");
      $display("test reset values done");
      rxVal = 8'($urandom);
      txVal = rxVal ^ (8'($urandom) | 8'h01);
      peer.deliver(rxVal);
      // plain write, never read-modify-write
      apb(1'b1, `DATA_BUFFER_OFFSET, txVal);
      @(negedge sys_clk);
      check(txLoad, 1'b1, "tx load pulse");
      check(txByte, txVal, "tx byte");
      rdchk(`DATA_BUFFER_OFFSET, rxVal, "rx byte");
      cfg = 8'($urandom);
      pre = cfg ^ 8'hFF;
      apb(1'b1, `BAUD_CONTROL_OFFSET, cfg);
      rdchk(`BAUD_CONTROL_OFFSET, cfg & 8'hF7, "baud read back");
      apb(1'b1, `PRESCALER_OFFSET, pre);
      rdchk(`PRESCALER_OFFSET, pre, "prescaler read back");
      apb(1'b0, 12'h030, 8'h00);
      check(err, 1'b1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(negedge sys_clk);
      check(txByte, txVal, "tx byte kept");
      rdchk(`DATA_BUFFER_OFFSET, rxVal, "rx byte kept");
      rdchk(`BAUD_CONTROL_OFFSET, 32'h0, "baud cleared");
      rdchk(`PRESCALER_OFFSET, 32'h0, "prescaler cleared");
      $display("test buffer and reset done");
      // last step runs from the oscillator source
      for (int i = 0; i < 12; i++)
      begin
         cfg = (i < 11) ? SWEEP[i] : 8'h00;
         // corner fine values 0 and 31 on two steps
         pre = {cfg[2:0], (i == 1) ? 5'h00 : (i == 2) ? 5'h1F : 5'($urandom)};
         apb(1'b1, `CONFIG_OFFSET, 8'h00);
         apb(1'b1, `BAUD_CONTROL_OFFSET, {2'h0, cfg[7:6], 1'b0, cfg[5:3]});
         // divisors change only while disabled
         apb(1'b1, `PRESCALER_OFFSET, pre);
         apb(1'b1, `CONFIG_OFFSET, (i < 11) ? 8'h01 : 8'h03);
         wait_bit(per);
         wait_bit(per);
         check(per, exp_bit(cfg, pre[4:0]) * ((i < 11) ? 1 : 4), "bit period");
         check(modEn, 1'b1, "module enabled");
      end
      $display("test baud sweep done");
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, `CONFIG_OFFSET, 8'h00);
         charLength9 <= k[0];
         apb(1'b1, `BAUD_CONTROL_OFFSET, {k[1], 7'h00});
         apb(1'b1, `PRESCALER_OFFSET, 8'h00);
         apb(1'b1, `CONFIG_OFFSET, 8'h01);
         apb(1'b1, `CONFIG_OFFSET, 8'h05);
         per = 0;
         while (breakLineLow !== 1'b1 && per < 8)
         begin
            @(negedge sys_clk);
            per++;
         end
         if (breakLineLow !== 1'b1) give_up("break start");
         rdchk(`STATUS_OFFSET, 32'h2, "break sending");
         while (breakLineLow === 1'b1 && per < 3000)
         begin
            @(negedge sys_clk);
            per++;
         end
         if (breakLineLow === 1'b1) give_up("break end");
         lenN = k[1] ? 13 + k[0] : 10 + k[0];
         check(breakBits, lenN, "break sent length");
      end
      $display("test break send done");
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, `CONFIG_OFFSET, 8'h00);
         charLength9 <= k[0];
         apb(1'b1, `BAUD_CONTROL_OFFSET, {1'b0, k[1], 6'h00});
         apb(1'b1, `CONFIG_OFFSET, 8'h01);
         apb(1'b1, `STATUS_OFFSET, 8'h01);
         lenN = 16 * (k[1] ? 11 + k[0] : 10 + k[0]);
         peer.hold_low(lenN - 1, ok);
         check(ok, 1'b1, "short low held");
         rdchk(`STATUS_OFFSET, 32'h0, "stretched zero filtered");
         // length confirmed by our own tick count
         peer.hold_low(lenN + 1, ok);
         check(ok, 1'b1, "long low held");
         rdchk(`STATUS_OFFSET, 32'h1, "break seen");
      end
      $display("test break detect done");
      wrap_up();
   end
endmodule : serial_baud_and_lin_break_config_tb_top
